// File: pkg/ssm_regs.svh
// constants for the serial-number and sleep-mode command logic
// assumes a 125 MHz system clock; included by bare name
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// opcodes
`define SSM_OP_READ_SN      8'hc3
`define SSM_OP_DEEP         8'hba
`define SSM_OP_HIB          8'hb9

// geometry
`define SSM_SN_BYTES        8
`define SSM_ROW_BITS        64
`define SSM_ROWS            32768
`define SSM_OP_LAST_BIT     3'h7
`define SSM_SN_LAST_BIT     6'h3f

// system clock period
`define SSM_CLK_NS          8

// low-power timing, plain defaults in ns
`define SSM_DEEP_ENTRY_NS   3000
`define SSM_DEEP_PULSE_NS   1000
`define SSM_DEEP_EXIT_NS    10000
`define SSM_HIB_ENTRY_NS    3000
`define SSM_HIB_EXIT_NS     20000

// host side timing, in system clocks
`define SSM_HOST_HALF       3
`define SSM_HOST_CS_PULSE   160
`define SSM_HOST_GAP        4

`endif

// File: pkg/ssm_pkg.sv
// types shared by both ends of the serial link
// assumes ssm_regs.svh for numeric constants
package ssm_pkg;

   typedef enum logic [2:0] {
      PWR_ACTIVE,
      PWR_ENTER_DEEP,
      PWR_DEEP,
      PWR_WAKE_DEEP,
      PWR_ENTER_HIB,
      PWR_HIB,
      PWR_WAKE_HIB
   } ssm_pwr_t;

   typedef enum logic [2:0] {
      HST_IDLE,
      HST_LEAD,
      HST_SHIFT,
      HST_PULSE,
      HST_GAP
   } ssm_host_t;

endpackage

// File: pkg/ssm_link_if.sv
// four-wire serial link between host controller and device
// the host gates so with so_oe before it samples
`timescale 1ns/100ps
interface ssm_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;

   modport dev (
      input  cs_n,
      input  sck,
      input  si,
      output so,
      output so_oe
   );

   modport host (
      output cs_n,
      output sck,
      output si,
      input  so,
      input  so_oe
   );
endinterface

// File: hdl/ssm_sync.sv
// three-stage synchroniser for a level from another domain
// output changes only once stages two and three agree
`timescale 1ns/100ps
module ssm_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic CLK,
   input  wire logic RSTN,
   input  wire logic D,
   output logic      Q
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         Q  <= INIT;
      end else begin
         s1 <= D;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            Q <= s3;
         end
      end
   end
endmodule

// File: hdl/ssm_dev.sv
// device end: serial-number read and the two low-power modes
// link logic runs on sck (mode 0), timers on the 125 MHz CLK
// Summary of operation
// R1: opcode c3h shifts serial number out
// R2: all eight bytes in one frame
// R3: wrap to first byte while clocked
// R4: least significant byte first
// R5: host lowers select before opcode
// R6: bah then select high: deep sleep
// R7: deep sleep ignores clock, output floats
// R8: long select pulse wakes from deep
// R9: host wakes by dummy frame or toggle
// R10: output floats while waking from deep
// R11: b9h then select high: hibernate
// R12: hibernate ignores clock, output floats
// R13: select falling edge starts hibernate exit
// R14: output floats, opcodes ignored while waking
// R15: host dummy frame then waits exit
// R16: serial row fetched whole once per pass
// R17: all delays are parameterised cycle counts
`timescale 1ns/100ps
`include "ssm_regs.svh"
module ssm_dev #(
   parameter logic [63:0] SERIAL_NUMBER  = 64'h0123_4567_89ab_cdef, // arbitrary value
   // R17: delays as cycle counts
   parameter int          DEEP_ENTRY_CYC = (`SSM_DEEP_ENTRY_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS,
   parameter int          DEEP_PULSE_CYC = (`SSM_DEEP_PULSE_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS,
   parameter int          DEEP_EXIT_CYC  = `SSM_DEEP_EXIT_NS / `SSM_CLK_NS,
   parameter int          HIB_ENTRY_CYC  = (`SSM_HIB_ENTRY_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS,
   parameter int          HIB_EXIT_CYC   = `SSM_HIB_EXIT_NS / `SSM_CLK_NS
) (
   input  wire logic CLK,
   input  wire logic RSTN,
   ssm_link_if.dev   LINK,
   output logic      DEEP_SLEEP,
   output logic      HIBERNATE,
   output logic      WAKING
);
   localparam logic [15:0] DEEP_ENTRY_LD = 16'(DEEP_ENTRY_CYC);
   localparam logic [15:0] DEEP_PULSE_LD = 16'(DEEP_PULSE_CYC);
   localparam logic [15:0] DEEP_EXIT_LD  = 16'(DEEP_EXIT_CYC);
   localparam logic [15:0] HIB_ENTRY_LD  = 16'(HIB_ENTRY_CYC);
   localparam logic [15:0] HIB_EXIT_LD   = 16'(HIB_EXIT_CYC);

   // link-domain state
   wire  logic       frame_rst;
   logic [2:0]       op_cnt;
   logic [6:0]       op_sh;
   logic             op_done;
   logic             rd_sn;
   logic [5:0]       sn_bit;
   logic [`SSM_ROW_BITS-1:0] sn_row;
   logic             so_q;
   logic             cmd_tgl;
   logic             cmd_hib;
   wire  logic [7:0] opcode;
   wire  logic       op_last;
   wire  logic       op_is_sleep;
   wire  logic       op_is_read;
   wire  logic [5:0] sn_index;

   // system-domain state
   ssm_pkg::ssm_pwr_t state;
   ssm_pkg::ssm_pwr_t next_state;
   logic [15:0]      tmr;
   logic [15:0]      next_tmr;
   logic [15:0]      low_cnt;
   logic [15:0]      next_low_cnt;
   logic             cs_n_s;
   logic             cs_prev;
   logic             tgl_s;
   logic             tgl_seen;
   logic             pend;
   logic             pend_hib;
   wire  logic       new_cmd;
   wire  logic       cs_fall;
   wire  logic       tmr_zero;
   wire  logic       asleep;

   // selection ends every frame, whatever state the counters hold
   assign frame_rst   = LINK.cs_n | ~RSTN;
   assign opcode      = {op_sh, LINK.si};
   assign op_last     = ~op_done & (op_cnt == `SSM_OP_LAST_BIT);
   assign op_is_sleep = (opcode == `SSM_OP_DEEP) | (opcode == `SSM_OP_HIB);
   assign op_is_read  = (opcode == `SSM_OP_READ_SN);
   // R4: low byte first, each byte msb first
   assign sn_index    = {sn_bit[5:3], ~sn_bit[2:0]};

   // R5: opcode only counted inside a selected frame
   always_ff @(posedge LINK.sck or posedge frame_rst) begin
      if (frame_rst) begin
         op_cnt  <= 3'h0;
         op_sh   <= 7'h00;
         op_done <= 1'b0;
         rd_sn   <= 1'b0;
      end else if (!op_done) begin
         op_sh   <= opcode[6:0];
         op_cnt  <= op_cnt + 3'h1;
         op_done <= op_last;
         // R1: serial read recognised
         rd_sn   <= op_last & op_is_read;
      end
   end

   // R2: bit counter runs from the end of the opcode to the end of the frame
   // R3: six-bit counter wraps to byte zero
   always_ff @(posedge LINK.sck or posedge frame_rst) begin
      if (frame_rst) begin
         sn_bit <= 6'h00;
         sn_row <= '0;
      end else begin
         if (rd_sn) begin
            sn_bit <= sn_bit + 6'h1;
         end
         // R16: whole row fetched once per pass
         if ((op_last && op_is_read) || (rd_sn && sn_bit == `SSM_SN_LAST_BIT)) begin
            sn_row <= SERIAL_NUMBER;
         end
      end
   end

   // launch on the falling edge so the host samples just before the next falling one
   always_ff @(negedge LINK.sck or posedge frame_rst) begin
      if (frame_rst) begin
         so_q <= 1'b0;
      end else begin
         so_q <= rd_sn ? sn_row[sn_index] : 1'b0;
      end
   end

   // sleep opcodes cross by toggle; cmd_hib is stable before the toggle
   always_ff @(posedge LINK.sck or negedge RSTN) begin
      if (!RSTN) begin
         cmd_tgl <= 1'b0;
         cmd_hib <= 1'b0;
      end else if (op_last && op_is_sleep) begin
         cmd_tgl <= ~cmd_tgl;
         cmd_hib <= (opcode == `SSM_OP_HIB);
      end
   end

   // R7: output floats while asleep
   // R10: and while waking from deep sleep
   // R12: and while hibernating
   // R14: and while waking from hibernate
   assign LINK.so    = so_q;
   assign LINK.so_oe = rd_sn & op_done & ~LINK.cs_n & ~asleep;

   ssm_sync #(
      .INIT (1'b1)
   ) u_cs_sync (
      .CLK  (CLK),
      .RSTN (RSTN),
      .D    (LINK.cs_n),
      .Q    (cs_n_s)
   );

   ssm_sync #(
      .INIT (1'b0)
   ) u_cmd_sync (
      .CLK  (CLK),
      .RSTN (RSTN),
      .D    (cmd_tgl),
      .Q    (tgl_s)
   );

   assign new_cmd  = tgl_s ^ tgl_seen;
   assign cs_fall  = cs_prev & ~cs_n_s;
   assign tmr_zero = (tmr == 16'h0000);
   assign asleep   = (state == ssm_pkg::PWR_DEEP) | (state == ssm_pkg::PWR_WAKE_DEEP) |
                     (state == ssm_pkg::PWR_HIB) | (state == ssm_pkg::PWR_WAKE_HIB);

   always_comb begin
      next_state   = state;
      next_tmr     = tmr_zero ? tmr : tmr - 16'h0001;
      next_low_cnt = 16'h0000;
      unique case (state)
         ssm_pkg::PWR_ACTIVE: begin
            // R6: deep entry after select rises
            // R11: hibernate entry after select rises
            if (pend && cs_n_s) begin
               next_state = pend_hib ? ssm_pkg::PWR_ENTER_HIB : ssm_pkg::PWR_ENTER_DEEP;
               next_tmr   = pend_hib ? HIB_ENTRY_LD : DEEP_ENTRY_LD;
            end
         end
         ssm_pkg::PWR_ENTER_DEEP: begin
            if (tmr_zero) begin
               next_state = ssm_pkg::PWR_DEEP;
            end
         end
         ssm_pkg::PWR_DEEP: begin
            // R8: count select low width
            // R9: a bare select pulse suffices
            if (!cs_n_s) begin
               next_low_cnt = low_cnt + 16'h0001;
               if (next_low_cnt >= DEEP_PULSE_LD) begin
                  next_state = ssm_pkg::PWR_WAKE_DEEP;
                  next_tmr   = DEEP_EXIT_LD;
               end
            end
         end
         ssm_pkg::PWR_WAKE_DEEP: begin
            if (tmr_zero) begin
               next_state = ssm_pkg::PWR_ACTIVE;
            end
         end
         ssm_pkg::PWR_ENTER_HIB: begin
            if (tmr_zero) begin
               next_state = ssm_pkg::PWR_HIB;
            end
         end
         ssm_pkg::PWR_HIB: begin
            // R13: first falling select starts exit
            if (cs_fall) begin
               next_state = ssm_pkg::PWR_WAKE_HIB;
               next_tmr   = HIB_EXIT_LD;
            end
         end
         ssm_pkg::PWR_WAKE_HIB: begin
            if (tmr_zero) begin
               next_state = ssm_pkg::PWR_ACTIVE;
            end
         end
         default: begin
            next_state = ssm_pkg::PWR_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state   <= ssm_pkg::PWR_ACTIVE;
         tmr     <= 16'h0000;
         low_cnt <= 16'h0000;
         cs_prev <= 1'b1;
      end else begin
         state   <= next_state;
         tmr     <= next_tmr;
         low_cnt <= next_low_cnt;
         cs_prev <= cs_n_s;
      end
   end

   // R14: commands while asleep or waking are dropped
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tgl_seen <= 1'b0;
         pend     <= 1'b0;
         pend_hib <= 1'b0;
      end else begin
         tgl_seen <= tgl_s;
         if (new_cmd && state == ssm_pkg::PWR_ACTIVE) begin
            pend     <= 1'b1;
            pend_hib <= cmd_hib;
         end else if (state != ssm_pkg::PWR_ACTIVE || cs_n_s) begin
            pend     <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         DEEP_SLEEP <= 1'b0;
         HIBERNATE  <= 1'b0;
         WAKING     <= 1'b0;
      end else begin
         DEEP_SLEEP <= (next_state == ssm_pkg::PWR_DEEP);
         HIBERNATE  <= (next_state == ssm_pkg::PWR_HIB);
         WAKING     <= (next_state == ssm_pkg::PWR_WAKE_DEEP) | (next_state == ssm_pkg::PWR_WAKE_HIB);
      end
   end
endmodule

// File: hdl/ssm_host.sv
// host end: frames opcodes, reads bytes back, makes wake pulses
// drives sck in mode 0 from CLK by a divider
`timescale 1ns/100ps
`include "ssm_regs.svh"
module ssm_host #(
   parameter int CS_PULSE_CYC = `SSM_HOST_CS_PULSE
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   ssm_link_if.host         LINK,
   input  wire logic        START,
   input  wire logic        SEND_OP,
   input  wire logic [7:0]  OPCODE,
   input  wire logic [3:0]  RD_BYTES,
   output logic             BUSY,
   output logic             DONE,
   output logic [63:0]      RD_DATA
);
   localparam logic [1:0]  HALF_LD  = 2'(`SSM_HOST_HALF - 1);
   localparam logic [15:0] PULSE_LD = 16'(CS_PULSE_CYC);
   localparam logic [15:0] GAP_LD   = 16'(`SSM_HOST_GAP);

   ssm_pkg::ssm_host_t state;
   logic [1:0]   div;
   logic [15:0]  wait_cnt;
   logic [7:0]   bits_left;
   logic [7:0]   bit_idx;
   logic [7:0]   tx_sh;
   logic [7:0]   rx_sh;
   logic         so_s;
   logic         cs_n_q;
   logic         sck_q;
   wire  logic   half_end;
   wire  logic   byte_end;
   wire  logic [7:0] rx_next;

   assign half_end = (div == 2'h0);
   assign rx_next  = {rx_sh[6:0], so_s};
   // R4: bytes after the opcode close on every eighth bit
   assign byte_end = (bit_idx[2:0] == `SSM_OP_LAST_BIT) && (bit_idx[7:3] != 5'h00);

   ssm_sync #(
      .INIT (1'b0)
   ) u_so_sync (
      .CLK  (CLK),
      .RSTN (RSTN),
      .D    (LINK.so & LINK.so_oe),
      .Q    (so_s)
   );

   assign LINK.cs_n = cs_n_q;
   assign LINK.sck  = sck_q;
   assign LINK.si   = tx_sh[7];
   assign BUSY      = (state != ssm_pkg::HST_IDLE);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state     <= ssm_pkg::HST_IDLE;
         div       <= 2'h0;
         wait_cnt  <= 16'h0000;
         bits_left <= 8'h00;
         bit_idx   <= 8'h00;
         tx_sh     <= 8'h00;
         rx_sh     <= 8'h00;
         cs_n_q    <= 1'b1;
         sck_q     <= 1'b0;
         DONE      <= 1'b0;
         RD_DATA   <= 64'h0;
      end else begin
         DONE <= 1'b0;
         div  <= half_end ? HALF_LD : div - 2'h1;
         unique case (state)
            ssm_pkg::HST_IDLE: begin
               if (START) begin
                  // R5: select goes low before the opcode
                  cs_n_q    <= 1'b0;
                  tx_sh     <= OPCODE;
                  // one fall per bit: opcode plus RD_BYTES bytes, no trailing byte
                  bits_left <= {1'b0, RD_BYTES, `SSM_OP_LAST_BIT};
                  bit_idx   <= 8'h00;
                  wait_cnt  <= PULSE_LD;
                  div       <= HALF_LD;
                  // R9: bare pulse when no opcode is sent
                  state     <= SEND_OP ? ssm_pkg::HST_LEAD : ssm_pkg::HST_PULSE;
               end
            end
            ssm_pkg::HST_LEAD: begin
               if (half_end) begin
                  state <= ssm_pkg::HST_SHIFT;
               end
            end
            ssm_pkg::HST_SHIFT: begin
               if (half_end) begin
                  sck_q <= ~sck_q;
                  if (sck_q) begin
                     // sample just before the falling edge, data settled a full period
                     tx_sh     <= {tx_sh[6:0], 1'b0};
                     rx_sh     <= rx_next;
                     bit_idx   <= bit_idx + 8'h01;
                     bits_left <= bits_left - 8'h01;
                     if (byte_end) begin
                        RD_DATA <= {rx_next, RD_DATA[63:8]};
                     end
                     if (bits_left == 8'h00) begin
                        state    <= ssm_pkg::HST_GAP;
                        cs_n_q   <= 1'b1;
                        wait_cnt <= GAP_LD;
                     end
                  end
               end
            end
            ssm_pkg::HST_PULSE: begin
               wait_cnt <= wait_cnt - 16'h0001;
               if (wait_cnt == 16'h0000) begin
                  cs_n_q   <= 1'b1;
                  wait_cnt <= GAP_LD;
                  state    <= ssm_pkg::HST_GAP;
               end
            end
            ssm_pkg::HST_GAP: begin
               wait_cnt <= wait_cnt - 16'h0001;
               if (wait_cnt == 16'h0000) begin
                  DONE  <= 1'b1;
                  state <= ssm_pkg::HST_IDLE;
               end
            end
            default: begin
               state <= ssm_pkg::HST_IDLE;
            end
         endcase
      end
   end
endmodule

// File: tb/ssm_link_properties.sv
// concurrent checks on the serial link and the device mode flags
// assumes instantiation in tb_top beside the link; all sampled on CLK
`timescale 1ns/100ps
module ssm_link_properties #(
   parameter int DEEP_ENTRY_CYC = 20,
   parameter int DEEP_PULSE_CYC = 10,
   parameter int HIB_ENTRY_CYC  = 20,
   parameter int HIB_EXIT_CYC   = 40
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic so,
   input wire logic so_oe,
   input wire logic DEEP_SLEEP,
   input wire logic HIBERNATE,
   input wire logic WAKING
);
   logic [15:0] hi_cnt;
   logic [15:0] lo_cnt;
   logic [15:0] wk_cnt;
   logic [7:0]  rises;
   logic        sck_q;
   wire         sck_rise = sck & ~sck_q;
   wire  [7:0]  rise_tot = rises + {7'h0, sck_rise};
   // counters stand in for long repetitions
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         hi_cnt <= 16'h0;
         lo_cnt <= 16'h0;
         wk_cnt <= 16'h0;
         rises <= 8'h0;
         sck_q <= 1'b0;
      end else begin
         hi_cnt <= cs_n ? hi_cnt + 16'h1 : 16'h0;
         lo_cnt <= cs_n ? 16'h0 : lo_cnt + 16'h1;
         wk_cnt <= WAKING ? wk_cnt + 16'h1 : 16'h0;
         rises <= cs_n ? 8'h0 : rise_tot;
         sck_q <= sck;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_wake_start;
      WAKING && !DEEP_SLEEP && !HIBERNATE;
   endsequence
   sequence s_long_pulse;
      !cs_n && lo_cnt >= 16'(DEEP_PULSE_CYC);
   endsequence
   a_sleep_so_off: assert property ((DEEP_SLEEP || HIBERNATE) |-> !so_oe)
      else $error("output driven while asleep");
   a_wake_so_off: assert property (WAKING |-> !so_oe)
      else $error("output driven while waking");
   a_cs_frames_so: assert property (cs_n |-> !so_oe)
      else $error("output driven while deselected");
   a_read_after_op: assert property ($rose(so_oe) |-> !cs_n && rise_tot == 8'h8)
      else $error("read data not after eighth opcode bit");
   a_so_steady: assert property (so_oe && $past(so_oe) && !$fell(sck) |-> $stable(so))
      else $error("serial output moved off the falling edge");
   a_deep_entry: assert property ($rose(DEEP_SLEEP) |-> cs_n && hi_cnt >= 16'(DEEP_ENTRY_CYC))
      else $error("deep sleep entered early");
   a_hib_entry: assert property ($rose(HIBERNATE) |-> cs_n && hi_cnt >= 16'(HIB_ENTRY_CYC))
      else $error("hibernate entered early");
   a_deep_wake: assert property ($fell(DEEP_SLEEP) |-> s_long_pulse ##0 s_wake_start)
      else $error("deep sleep left without a long select pulse");
   a_hib_wake: assert property ($fell(HIBERNATE) |-> s_wake_start ##0 (!cs_n && lo_cnt <= 16'h8))
      else $error("hibernate left without a select fall");
   a_wake_bound: assert property (WAKING |-> wk_cnt < 16'(HIB_EXIT_CYC + 2))
      else $error("wakeup runs too long");
endmodule

// File: tb/tb_top.sv
// self-checking bench: host and device joined by the serial link
// assumes shortened delay parameters; host makes sck from CLK
`timescale 1ns/100ps
module tb_top;
   localparam logic [63:0] SN = 64'h1122_3344_5566_7788; // arbitrary value
   localparam int          DE = 20;
   localparam int          DP = 10;
   localparam int          DX = 30;
   localparam int          HE = 20;
   localparam int          HX = 40;
   typedef struct {logic [3:0] nb; logic [63:0] exp; logic [63:0] msk;} ssm_row_t;
   logic        CLK, RSTN, START, SEND_OP, BUSY, DONE, DEEP_SLEEP, HIBERNATE, WAKING;
   logic [7:0]  OPCODE;
   logic [3:0]  RD_BYTES;
   logic [63:0] RD_DATA;
   wire  [3:0]  flags = {DONE, DEEP_SLEEP, HIBERNATE, WAKING};
   int          errors, n_tests, cnt;
   ssm_row_t    rows [5];
   ssm_link_if link();
   ssm_dev #(.SERIAL_NUMBER(SN), .DEEP_ENTRY_CYC(DE), .DEEP_PULSE_CYC(DP), .DEEP_EXIT_CYC(DX),
      .HIB_ENTRY_CYC(HE), .HIB_EXIT_CYC(HX)) ssm_dev_i (.CLK(CLK), .RSTN(RSTN), .LINK(link),
      .DEEP_SLEEP(DEEP_SLEEP), .HIBERNATE(HIBERNATE), .WAKING(WAKING));
   ssm_host #(.CS_PULSE_CYC(20)) ssm_host_i (.CLK(CLK), .RSTN(RSTN), .LINK(link), .START(START),
      .SEND_OP(SEND_OP), .OPCODE(OPCODE), .RD_BYTES(RD_BYTES), .BUSY(BUSY), .DONE(DONE), .RD_DATA(RD_DATA));
   ssm_link_properties #(.DEEP_ENTRY_CYC(DE), .DEEP_PULSE_CYC(DP), .HIB_ENTRY_CYC(HE), .HIB_EXIT_CYC(HX))
      ssm_link_properties_i (.CLK(CLK), .RSTN(RSTN), .cs_n(link.cs_n), .sck(link.sck), .so(link.so),
      .so_oe(link.so_oe), .DEEP_SLEEP(DEEP_SLEEP), .HIBERNATE(HIBERNATE), .WAKING(WAKING));
   task automatic final_report();
      if (errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bounded poll; a hang is counted and ends the run
   task automatic wait_on(input int idx, input logic lvl, output int c);
      for (c = 0; c < 3000; c++) begin
         @(posedge CLK);
         #1;
         if (flags[idx] === lvl) begin
            return;
         end
      end
      errors++;
      $display("mismatch at %0t: wait ran out", $time);
      final_report();
   endtask
   task automatic kick(input logic [7:0] op, input logic with_op, input logic [3:0] nb);
      @(posedge CLK);
      #1;
      START = 1'b1;
      SEND_OP = with_op;
      OPCODE = op;
      RD_BYTES = nb;
      @(posedge CLK);
      #1;
      START = 1'b0;
   endtask
   task automatic run(input logic [7:0] op, input logic with_op, input logic [3:0] nb);
      int c;
      kick(op, with_op, nb);
      wait_on(3, 1'b1, c);
   endtask
   task automatic idle_check();
      check(64'({link.cs_n, link.sck, link.so_oe, BUSY, DONE, DEEP_SLEEP, HIBERNATE, WAKING}), 64'h80);
      check(RD_DATA, 64'h0);
   endtask
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      RSTN = 1'b0;
      START = 1'b0;
      SEND_OP = 1'b0;
      OPCODE = 8'h0;
      RD_BYTES = 4'h0;
      errors = 0;
      n_tests = 0;
      rows = '{'{4'h8, SN, '1}, '{4'h4, {SN[31:0], 32'h0}, {32'hffff_ffff, 32'h0}},
         '{4'h9, {SN[7:0], SN[63:8]}, '1}, '{4'hc, {SN[31:0], SN[63:32]}, '1},
         '{4'hf, {SN[55:0], SN[63:56]}, '1}};
      repeat (10) @(posedge CLK);
      #1;
      idle_check();
      RSTN = 1'b1;
      foreach (rows[i]) begin
         run(8'hc3, 1'b1, rows[i].nb);
         check(RD_DATA & rows[i].msk, rows[i].exp);
      end
      // deep sleep entry, bare select pulse wake, then a normal read
      run(8'hba, 1'b1, 4'h0);
      wait_on(2, 1'b1, cnt);
      check(64'(cnt >= DE - 2 && cnt <= DE + 8), 64'h1);
      kick(8'h00, 1'b0, 4'h0);
      wait_on(0, 1'b1, cnt);
      check(64'(DEEP_SLEEP), 64'h0);
      wait_on(0, 1'b0, cnt);
      check(64'(cnt >= DX - 1 && cnt <= DX + 1), 64'h1);
      run(8'hc3, 1'b1, 4'h8);
      check(RD_DATA, SN);
      // hibernate, dummy read wakes, wait out the exit delay
      run(8'hb9, 1'b1, 4'h0);
      wait_on(1, 1'b1, cnt);
      check(64'(cnt >= HE - 2 && cnt <= HE + 8), 64'h1);
      kick(8'hc3, 1'b1, 4'h8);
      wait_on(0, 1'b1, cnt);
      check(64'(HIBERNATE), 64'h0);
      wait_on(0, 1'b0, cnt);
      check(64'(cnt >= HX - 1 && cnt <= HX + 1), 64'h1);
      wait_on(3, 1'b1, cnt);
      run(8'hc3, 1'b1, 4'h8);
      check(RD_DATA, SN);
      // reset in mid-frame, then a clean read
      kick(8'hc3, 1'b1, 4'h8);
      repeat (50) @(posedge CLK);
      #1;
      RSTN = 1'b0;
      #1;
      idle_check();
      repeat (3) @(posedge CLK);
      #1;
      RSTN = 1'b1;
      run(8'hc3, 1'b1, 4'h8);
      check(RD_DATA, SN);
      final_report();
   end
endmodule
